//--- core/stc_timer.v
// timer pair with split mode, control register and avalon slave
//
// Functional notes
// R01 - split mode: two independent 8-bit counters
// R02 - low byte uses first run, source, gate, flag
// R03 - high byte times only, never external input
// R04 - high byte run by second run bit
// R05 - high byte overflow sets second overflow flag
// R06 - split: second timer no flag, no external
// R07 - second overflow pulse still delivered out
// R08 - split: second runs modes 0-2, halts 3
// R09 - overflow flags, software or vector clear
// R10 - run bits enable and disable timers
// R11 - external flags by level or edge
// R12 - control resets zero, single-bit set/clear
// R13 - count when run and gate satisfied
// R14 - external count on synced falling edge
`timescale 1ns/1ns
`include "stc_consts.vh"
module stc_timer (
  input wire core_clk,
  input wire rst_n,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire firstCountPin,
  input wire secondCountPin,
  input wire extIrqAInput,
  input wire extIrqBInput,
  input wire firstVectorAck,
  input wire secondVectorAck,
  output wire firstTimerIrq,
  output wire secondTimerIrq,
  output wire extIrqAReq,
  output wire extIrqBReq,
  output reg secondOverflowPulse,
  output reg irq
);

  // one counting step: {overflow, high byte, low byte}
  function [16:0] stepCount;
    input [1:0] mode;
    input [15:0] cnt;
    reg [13:0] wide13;
    reg [16:0] wide16;
    reg [8:0] low9;
    begin
      wide13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
      wide16 = {1'b0, cnt} + 17'h00001;
      low9 = {1'b0, cnt[7:0]} + 9'h001;
      case (mode)
        `STC_MODE_13: begin
          stepCount = {wide13[13], wide13[12:5], cnt[7:5], wide13[4:0]};
        end
        `STC_MODE_16: begin
          stepCount = wide16;
        end
        `STC_MODE_RELOAD: begin
          if (low9[8]) begin
            stepCount = {1'b1, cnt[15:8], cnt[15:8]};
          end else begin
            stepCount = {1'b0, cnt[15:8], low9[7:0]};
          end
        end
        default: begin
          stepCount = {low9[8], cnt[15:8], low9[7:0]};
        end
      endcase
    end
  endfunction

  reg [7:0] tctl_q;
  reg [7:0] tctl_d;
  reg [7:0] modeSel_q;
  reg [3:0] cfg_q;
  reg [7:0] cntLoA_q;
  reg [7:0] cntLoA_d;
  reg [7:0] cntHiA_q;
  reg [7:0] cntHiA_d;
  reg [7:0] tl1_q;
  reg [7:0] tl1_d;
  reg [7:0] th1_q;
  reg [7:0] th1_d;
  reg [3:0] intStat_q;
  reg [3:0] intStat_d;
  reg [3:0] intEn_q;
  reg [7:0] preCnt_q;
  reg [31:0] readMux;

  wire t0Level;
  wire t0Prev;
  wire t1Level;
  wire t1Prev;
  wire intALevel;
  wire intAPrev;
  wire intBLevel;
  wire intBPrev;

  stc_pin_sync syncT0 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(firstCountPin),
    .syncLevel(t0Level),
    .prevLevel(t0Prev)
  );

  stc_pin_sync syncT1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(secondCountPin),
    .syncLevel(t1Level),
    .prevLevel(t1Prev)
  );

  stc_pin_sync syncIntA (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(extIrqAInput),
    .syncLevel(intALevel),
    .prevLevel(intAPrev)
  );

  stc_pin_sync syncIntB (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn(extIrqBInput),
    .syncLevel(intBLevel),
    .prevLevel(intBPrev)
  );

  // bus decode; a write lands on the edge where waitrequest is low
  wire [9:0] regIdx = avs_address[11:2];
  wire wrEn = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire [7:0] wrByte = avs_writedata[7:0];
  wire wrTctl = wrEn & (regIdx == `STC_IDX_TCTL);
  wire wrTset = wrEn & (regIdx == `STC_IDX_TSET);
  wire wrTclr = wrEn & (regIdx == `STC_IDX_TCLR);
  wire wrModeSel = wrEn & (regIdx == `STC_IDX_MODE);
  wire wrLoA = wrEn & (regIdx == `STC_IDX_LOA);
  wire wrHiA = wrEn & (regIdx == `STC_IDX_HIA);
  wire wrTl1 = wrEn & (regIdx == `STC_IDX_TL1);
  wire wrTh1 = wrEn & (regIdx == `STC_IDX_TH1);
  wire wrCfg = wrEn & (regIdx == `STC_IDX_CFG);
  wire wrIclr = wrEn & (regIdx == `STC_IDX_ICLR);
  wire wrIen = wrEn & (regIdx == `STC_IDX_IEN);

  // count sources
  wire preTick = (preCnt_q == (`STC_PRESCALE_DIV - 8'h01));
  wire clkTick0 = cfg_q[`STC_CFG_SYS0] | preTick;
  wire clkTick1 = cfg_q[`STC_CFG_SYS1] | preTick;
  // R14 falling edges
  wire t0Fall = t0Prev & ~t0Level;
  wire t1Fall = t1Prev & ~t1Level;

  // external inputs at configured polarity
  wire actA = cfg_q[`STC_CFG_POLA] ? intALevel : ~intALevel;
  wire actAPrev = cfg_q[`STC_CFG_POLA] ? intAPrev : ~intAPrev;
  wire actB = cfg_q[`STC_CFG_POLB] ? intBLevel : ~intBLevel;
  wire actBPrev = cfg_q[`STC_CFG_POLB] ? intBPrev : ~intBPrev;

  wire [1:0] mode0 = modeSel_q[`STC_M0_HI:`STC_M0_LO];
  wire [1:0] mode1 = modeSel_q[`STC_M1_HI:`STC_M1_LO];
  wire split = (mode0 == `STC_MODE_SPLIT);

  // R13 gate control; R02 low byte keeps first timer controls
  wire run0 = tctl_q[`STC_RUN_A] & (~modeSel_q[`STC_GATE_A] | actA);
  // R14 external source select
  wire tick0 = modeSel_q[`STC_CT0] ? t0Fall : clkTick0;
  wire [16:0] step0 = stepCount(mode0, {cntHiA_q, cntLoA_q});
  wire cnt0 = run0 & tick0;
  // R01 low byte wraps alone in split mode
  wire ovf0 = cnt0 & step0[16];

  // R03 high byte on core or prescaled clock; R04 second run bit
  wire runHi = split & tctl_q[`STC_RUN_B] & clkTick0;
  wire [8:0] hiNext = {1'b0, cntHiA_q} + 9'h001;
  wire ovfHi = runHi & hiNext[8];

  // R08 mode field alone runs the second timer while split
  wire run1Split = (mode1 != `STC_MODE_SPLIT);
  // R10 R13 normal run control
  wire run1Norm = tctl_q[`STC_RUN_B] & (~modeSel_q[`STC_GATE_B] | actB) &
                  (mode1 != `STC_MODE_SPLIT);
  wire run1 = split ? run1Split : run1Norm;
  // R06 no external clocking while split
  wire tick1 = (modeSel_q[`STC_CT1] & ~split) ? t1Fall : clkTick1;
  wire [16:0] step1 = stepCount(mode1, {th1_q, tl1_q});
  wire cnt1 = run1 & tick1;
  wire ovf1 = cnt1 & step1[16];

  // R05 R06 flag source for the second overflow
  wire tf1Set = split ? ovfHi : ovf1;

  // R11 level or edge event
  wire ieASet = tctl_q[`STC_EXT_TYPE_A] ? (actA & ~actAPrev) : actA;
  wire ieBSet = tctl_q[`STC_EXT_TYPE_B] ? (actB & ~actBPrev) : actB;

  wire [3:0] events = {ieBSet, ieASet, tf1Set, ovf0};

  // counter next values; bus writes win over counting
  always @* begin
    cntLoA_d = cntLoA_q;
    cntHiA_d = cntHiA_q;
    tl1_d = tl1_q;
    th1_d = th1_q;
    if (cnt0) begin
      cntLoA_d = step0[7:0];
      if (!split) begin
        cntHiA_d = step0[15:8];
      end
    end
    if (runHi) begin
      cntHiA_d = hiNext[7:0];
    end
    if (cnt1) begin
      tl1_d = step1[7:0];
      th1_d = step1[15:8];
    end
    if (wrLoA) begin
      cntLoA_d = wrByte;
    end
    if (wrHiA) begin
      cntHiA_d = wrByte;
    end
    if (wrTl1) begin
      tl1_d = wrByte;
    end
    if (wrTh1) begin
      th1_d = wrByte;
    end
  end

  // control register: software, then vector clears, then hardware sets
  always @* begin
    tctl_d = tctl_q;
    // R12 whole write or single-bit set and clear
    if (wrTctl) begin
      tctl_d = wrByte;
    end
    if (wrTset) begin
      tctl_d = tctl_q | wrByte;
    end
    if (wrTclr) begin
      tctl_d = tctl_q & ~wrByte;
    end
    // R09 cleared on vector
    if (firstVectorAck) begin
      tctl_d[`STC_OVF_A] = 1'b0;
    end
    if (secondVectorAck) begin
      tctl_d[`STC_OVF_B] = 1'b0;
    end
    // R09 overflow sets flag, set beats clear
    if (ovf0) begin
      tctl_d[`STC_OVF_A] = 1'b1;
    end
    // R05 high byte or second timer overflow
    if (tf1Set) begin
      tctl_d[`STC_OVF_B] = 1'b1;
    end
    // R11 external flags
    if (ieASet) begin
      tctl_d[`STC_EXT_FLAG_A] = 1'b1;
    end
    if (ieBSet) begin
      tctl_d[`STC_EXT_FLAG_B] = 1'b1;
    end
  end

  // sticky event status, write-one clear, set wins
  always @* begin
    intStat_d = intStat_q;
    if (wrIclr) begin
      intStat_d = intStat_q & ~avs_writedata[3:0];
    end
    intStat_d = intStat_d | events;
  end

  always @* begin
    readMux = 32'h00000000;
    case (regIdx)
      `STC_IDX_TCTL: readMux[7:0] = tctl_q;
      `STC_IDX_MODE: readMux[7:0] = modeSel_q;
      `STC_IDX_LOA: readMux[7:0] = cntLoA_q;
      `STC_IDX_HIA: readMux[7:0] = cntHiA_q;
      `STC_IDX_TL1: readMux[7:0] = tl1_q;
      `STC_IDX_TH1: readMux[7:0] = th1_q;
      `STC_IDX_CFG: readMux[3:0] = cfg_q;
      `STC_IDX_ISTAT: readMux[3:0] = intStat_q;
      `STC_IDX_IEN: readMux[3:0] = intEn_q;
      default: readMux = 32'h00000000;
    endcase
  end

  // avalon handshake: one wait cycle, then accept
  always @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= readMux;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      preCnt_q <= 8'h00;
    end else if (preTick) begin
      preCnt_q <= 8'h00;
    end else begin
      preCnt_q <= preCnt_q + 8'h01;
    end
  end

  // R12 control state resets to zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tctl_q <= `STC_TCTL_RST;
      modeSel_q <= `STC_MODE_RST;
      cfg_q <= `STC_CFG_RST;
      cntLoA_q <= `STC_CNT_RST;
      cntHiA_q <= `STC_CNT_RST;
      tl1_q <= `STC_CNT_RST;
      th1_q <= `STC_CNT_RST;
      intStat_q <= `STC_INT_RST;
      intEn_q <= `STC_INT_RST;
      secondOverflowPulse <= 1'b0;
      irq <= 1'b0;
    end else begin
      tctl_q <= tctl_d;
      cntLoA_q <= cntLoA_d;
      cntHiA_q <= cntHiA_d;
      tl1_q <= tl1_d;
      th1_q <= th1_d;
      intStat_q <= intStat_d;
      if (wrModeSel) begin
        modeSel_q <= wrByte;
      end
      if (wrCfg) begin
        cfg_q <= wrByte[3:0];
      end
      if (wrIen) begin
        intEn_q <= wrByte[3:0];
      end
      // R07 overflow pulse for baud and conversion start
      secondOverflowPulse <= ovf1;
      irq <= |(intStat_d & (wrIen ? wrByte[3:0] : intEn_q));
    end
  end

  assign firstTimerIrq = tctl_q[`STC_OVF_A];
  assign secondTimerIrq = tctl_q[`STC_OVF_B];
  assign extIrqAReq = tctl_q[`STC_EXT_FLAG_A];
  assign extIrqBReq = tctl_q[`STC_EXT_FLAG_B];

endmodule // stc_timer

//--- core/stc_consts.vh
// constants for the split timer and timer control block
`ifndef STC_CONSTS_VH
`define STC_CONSTS_VH

// register indices; byte address is four times the index
`define STC_IDX_TCTL 10'h088
`define STC_IDX_MODE 10'h089
`define STC_IDX_LOA 10'h08A
`define STC_IDX_HIA 10'h08B
`define STC_IDX_TL1 10'h08C
`define STC_IDX_TH1 10'h08D
`define STC_IDX_CFG 10'h08E
`define STC_IDX_TSET 10'h08F
`define STC_IDX_TCLR 10'h090
`define STC_IDX_ISTAT 10'h091
`define STC_IDX_ICLR 10'h092
`define STC_IDX_IEN 10'h093

// timer_control_status fields
`define STC_OVF_B 7
`define STC_RUN_B 6
`define STC_OVF_A 5
`define STC_RUN_A 4
`define STC_EXT_FLAG_B 3
`define STC_EXT_TYPE_B 2
`define STC_EXT_FLAG_A 1
`define STC_EXT_TYPE_A 0

// timer_mode_select_reg fields
`define STC_GATE_B 7
`define STC_CT1 6
`define STC_M1_HI 5
`define STC_M1_LO 4
`define STC_GATE_A 3
`define STC_CT0 2
`define STC_M0_HI 1
`define STC_M0_LO 0

// configuration fields
`define STC_CFG_SYS0 0
`define STC_CFG_SYS1 1
`define STC_CFG_POLA 2
`define STC_CFG_POLB 3

// interrupt status fields
`define STC_EV_OVF0 0
`define STC_EV_OVF1 1
`define STC_EV_EXTA 2
`define STC_EV_EXTB 3

// timer modes
`define STC_MODE_13 2'h0
`define STC_MODE_16 2'h1
`define STC_MODE_RELOAD 2'h2
`define STC_MODE_SPLIT 2'h3

// reset values
`define STC_TCTL_RST 8'h00
`define STC_MODE_RST 8'h00
`define STC_CFG_RST 4'h0
`define STC_CNT_RST 8'h00
`define STC_INT_RST 4'h0

// prescaled clock divides the core clock by this count
`define STC_PRESCALE_DIV 8'h0C

`endif

//--- core/stc_pin_sync.v
// two-stage pin synchroniser with a delayed copy for edge detection
`timescale 1ns/1ns
module stc_pin_sync (
  input wire core_clk,
  input wire rst_n,
  input wire pinIn,
  output wire syncLevel,
  output wire prevLevel
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pinIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign syncLevel = sync_q;
  assign prevLevel = prev_q;

endmodule // stc_pin_sync

//--- tb/stc_timer_sva.sv
// port checker for the split timer block
`timescale 1ns/1ns
module stc_timer_chk (
  input wire core_clk,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire firstVectorAck,
  input wire secondVectorAck,
  input wire firstTimerIrq,
  input wire secondTimerIrq,
  input wire extIrqAReq,
  input wire extIrqBReq,
  input wire secondOverflowPulse,
  input wire irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer");
  property p_wait_stand;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_stand: assert property (p_wait_stand) else $error("answer too long");
  property p_idle_wait;
    !avs_read && !avs_write |=> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("idle answer");
  property p_rd_upper;
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_tf0_clr;
    $fell(firstTimerIrq) |-> $past(firstVectorAck) || $past(avs_write);
  endproperty
  a_tf0_clr: assert property (p_tf0_clr) else $error("first flag lost");
  property p_tf1_clr;
    $fell(secondTimerIrq) |-> $past(secondVectorAck) || $past(avs_write);
  endproperty
  a_tf1_clr: assert property (p_tf1_clr) else $error("second flag lost");
  property p_iea_clr;
    $fell(extIrqAReq) |-> $past(avs_write);
  endproperty
  a_iea_clr: assert property (p_iea_clr) else $error("ext a flag lost");
  property p_ieb_clr;
    $fell(extIrqBReq) |-> $past(avs_write);
  endproperty
  a_ieb_clr: assert property (p_ieb_clr) else $error("ext b flag lost");
  c_irq: cover property ($rose(irq));
  c_pulse: cover property (secondOverflowPulse);
  c_extb: cover property ($rose(extIrqBReq));
endmodule // stc_timer_chk
bind stc_timer stc_timer_chk u_chk (.core_clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .firstVectorAck, .secondVectorAck, .firstTimerIrq, .secondTimerIrq,
  .extIrqAReq, .extIrqBReq, .secondOverflowPulse, .irq);

//--- tb/stc_timer_tb.sv
// self-checking bench for the split timer block
`timescale 1ns/1ns
`include "stc_consts.vh"
module stc_timer_tb;
  reg core_clk = 1'h0;
  reg rst_n = 1'h0;
  reg [11:0] adr = 12'h000;
  reg rd = 1'h0;
  reg wr = 1'h0;
  reg [31:0] wd = 32'h0;
  reg [3:0] pins = 4'hF;
  reg [1:0] acks = 2'h0;
  wire [31:0] rdData;
  wire waitReq;
  wire [5:0] outs;
  integer checks = 0;
  integer failCount = 0;
  always #2 core_clk = ~core_clk;
  stc_timer dut (.core_clk(core_clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdData),
    .avs_waitrequest(waitReq), .firstCountPin(pins[0]), .secondCountPin(pins[1]),
    .extIrqAInput(pins[2]), .extIrqBInput(pins[3]), .firstVectorAck(acks[0]),
    .secondVectorAck(acks[1]), .firstTimerIrq(outs[0]), .secondTimerIrq(outs[1]),
    .extIrqAReq(outs[2]), .extIrqBReq(outs[3]), .secondOverflowPulse(outs[4]), .irq(outs[5]));
  task results;
    begin
      $display("checks %0d errors %0d", checks, failCount);
      if (failCount == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task tmo;
    begin
      failCount = failCount + 1;
      $display("[ERR] %0t wait ran out", $time);
      results;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failCount = failCount + 1;
        $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cb(input integer idx, input e);
    begin
      chk({7'h00, outs[idx]}, {7'h00, e});
    end
  endtask
  task bus(input w, input [9:0] idx, input [7:0] d, output [7:0] q);
    integer n;
    begin
      n = 0;
      adr <= {idx, 2'h0};
      wd <= {24'h000000, d};
      rd <= ~w;
      wr <= w;
      @(posedge core_clk);
      while (waitReq !== 1'h0 && n < 20) begin
        @(posedge core_clk);
        n = n + 1;
      end
      q = rdData[7:0];
      rd <= 1'h0;
      wr <= 1'h0;
      @(posedge core_clk);
      if (n == 20) tmo;
    end
  endtask
  task w(input [9:0] i, input [7:0] d);
    reg [7:0] q;
    begin
      bus(1'h1, i, d, q);
    end
  endtask
  task r(input [9:0] i, input [7:0] e);
    reg [7:0] q;
    begin
      bus(1'h0, i, 8'h00, q);
      chk(q, e);
    end
  endtask
  task waitHi(input integer idx, input integer lim);
    integer n;
    begin
      n = 0;
      while (outs[idx] !== 1'h1 && n < lim) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == lim) tmo;
      checks = checks + 1;
    end
  endtask
  task ack(input [1:0] a);
    begin
      acks <= a;
      @(posedge core_clk);
      acks <= 2'h0;
      @(posedge core_clk);
    end
  endtask
  task fall0(input integer k);
    repeat (k) begin
      pins[0] <= 1'h0;
      repeat (4) @(posedge core_clk);
      pins[0] <= 1'h1;
      repeat (4) @(posedge core_clk);
    end
  endtask
  task s_reset;
    begin
      r(`STC_IDX_TCTL, `STC_TCTL_RST);
      r(10'h0A0, 8'h00);
    end
  endtask
  task s_low;
    begin
      w(`STC_IDX_CFG, 8'h01);
      w(`STC_IDX_LOA, 8'hF0);
      w(`STC_IDX_MODE, 8'h03);
      w(`STC_IDX_TSET, 8'h10);
      waitHi(0, 40);
      r(`STC_IDX_HIA, 8'h00);
      r(`STC_IDX_TCTL, 8'h30);
      ack(2'h1);
      cb(0, 1'h0);
      w(`STC_IDX_TCLR, 8'h10);
      r(`STC_IDX_ISTAT, 8'h01);
      w(`STC_IDX_IEN, 8'h01);
      @(posedge core_clk);
      cb(5, 1'h1);
      w(`STC_IDX_ICLR, 8'h01);
      @(posedge core_clk);
      cb(5, 1'h0);
    end
  endtask
  task s_high;
    begin
      w(`STC_IDX_CFG, 8'h03);
      w(`STC_IDX_TL1, 8'hF0);
      w(`STC_IDX_TH1, 8'hF0);
      w(`STC_IDX_MODE, 8'h27);
      waitHi(4, 40);
      cb(1, 1'h0);
      w(`STC_IDX_HIA, 8'hF8);
      w(`STC_IDX_TSET, 8'h40);
      waitHi(1, 40);
      ack(2'h2);
      cb(1, 1'h0);
      w(`STC_IDX_TCLR, 8'h40);
    end
  endtask
  task s_halt;
    integer n;
    integer k;
    begin
      w(`STC_IDX_MODE, 8'h33);
      repeat (2) @(posedge core_clk);
      k = 0;
      for (n = 0; n < 300; n = n + 1) begin
        @(posedge core_clk);
        if (outs[4] === 1'h1) k = k + 1;
      end
      chk(k[7:0], 8'h00);
    end
  endtask
  task s_cnt;
    begin
      w(`STC_IDX_LOA, 8'h00);
      w(`STC_IDX_MODE, 8'h07);
      w(`STC_IDX_TSET, 8'h10);
      fall0(3);
      r(`STC_IDX_LOA, 8'h03);
      w(`STC_IDX_MODE, 8'h0F);
      fall0(2);
      r(`STC_IDX_LOA, 8'h03);
      w(`STC_IDX_TCLR, 8'h10);
    end
  endtask
  task s_ext;
    begin
      pins[2] <= 1'h0;
      waitHi(2, 10);
      pins[2] <= 1'h1;
      repeat (4) @(posedge core_clk);
      w(`STC_IDX_TCLR, 8'h02);
      w(`STC_IDX_TSET, 8'h01);
      pins[2] <= 1'h0;
      waitHi(2, 10);
      w(`STC_IDX_TCLR, 8'h02);
      repeat (6) @(posedge core_clk);
      cb(2, 1'h0);
      pins[2] <= 1'h1;
      w(`STC_IDX_CFG, 8'h0B);
      waitHi(3, 10);
      pins[3] <= 1'h0;
      // let the synchroniser see the inactive level before clearing
      repeat (3) @(posedge core_clk);
      w(`STC_IDX_TCLR, 8'h08);
      cb(3, 1'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    s_reset;
    s_low;
    s_high;
    s_halt;
    s_cnt;
    s_ext;
    results;
  end
endmodule // stc_timer_tb
